// file: rtl/dac_byte_loader_host.sv
// Host controller that loads a 12-bit code into a double-buffered converter over
// an 8-bit bus with two section selects, a write strobe and a load strobe.
// Assumes a single 125 MHz clock; the converter pins are driven straight from flops.
//
// Behaviour
// - Bus is right-justified: low byte on all lines, high nibble on lines 3..0
// - Host may write low byte and high nibble in either order
// - Load overlapping a write stays low the overlap hold time after write rises
// - Load tied to high select: write low byte first, second write transfers
// - Load tied to low select: write high nibble first, second write transfers
`timescale 1ns/10ps
`include "dac_loader_consts.svh"
module dac_byte_loader_host (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire dac_loader_pkg::request_t req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [11:0] applied_code_o,
  output logic [7:0] data_o,
  output logic low_byte_select_n_o,
  output logic high_nibble_select_n_o,
  output logic write_n_o,
  output logic load_output_n_o
);
  // Sequencer state and the request held for the whole transfer
  dac_loader_pkg::state_t state;
  dac_loader_pkg::state_t next_state;
  dac_loader_pkg::request_t req;
  dac_loader_pkg::pins_t next_pins;
  dac_loader_pkg::pins_t pins;
  logic [`WAIT_W-1:0] wait_cnt;
  logic [`WAIT_W-1:0] next_wait;
  logic second;
  logic [11:0] staged;
  logic next_second;
  logic next_high;
  logic next_tied;
  dac_loader_pkg::request_t next_req;

  // Bus byte for a section, right-justified on the 8 lines
  function automatic logic [7:0] section_byte(input logic [11:0] code, input logic high);
    section_byte = high ? {4'h0, code[11:8]} : code[7:0];
  endfunction : section_byte

  // Which section goes first; the tied select must be the second write
  function automatic logic high_first(input dac_loader_pkg::mode_t m);
    high_first = (m == dac_loader_pkg::MODE_AUTO_LOW);
  endfunction : high_first

  // Automatic modes tie the load strobe to one of the selects
  function automatic logic is_auto(input dac_loader_pkg::mode_t m);
    is_auto = (m == dac_loader_pkg::MODE_AUTO_HIGH) || (m == dac_loader_pkg::MODE_AUTO_LOW);
  endfunction : is_auto

  // Cycle count for a wait, cut to the counter width on purpose
  function automatic logic [`WAIT_W-1:0] cyc(input int n);
    cyc = `WAIT_W'(n - 1);
  endfunction : cyc

  // Section now being written, and whether its select carries the load strobe
  logic cur_high;
  logic load_tied;
  assign cur_high = high_first(req.mode) ^ second;
  // In automatic modes the load strobe rides the select of the second section
  assign load_tied = second && is_auto(req.mode);

  // Sequencer: setup, write strobe, hold, then the second section or the load
  always_comb begin
    next_state = state;
    next_wait = (wait_cnt != '0) ? wait_cnt - `WAIT_W'(1) : wait_cnt;
    case (state)
      dac_loader_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          next_state = dac_loader_pkg::ST_SETUP;
          next_wait = cyc(`DATA_SETUP_CYC);
        end
      end
      dac_loader_pkg::ST_SETUP: begin
        if (wait_cnt == '0) begin
          next_state = dac_loader_pkg::ST_STROBE;
          next_wait = cyc(`STROBE_LOW_CYC);
        end
      end
      dac_loader_pkg::ST_STROBE: begin
        if (wait_cnt == '0) begin
          // Tied load must outlast the write by the overlap hold time
          next_state = load_tied ? dac_loader_pkg::ST_OVERLAP : dac_loader_pkg::ST_HOLD;
          next_wait = load_tied ? cyc(`OVERLAP_HOLD_CYC) : cyc(`SELECT_HOLD_CYC);
        end
      end
      dac_loader_pkg::ST_OVERLAP: begin
        if (wait_cnt == '0) begin
          next_state = dac_loader_pkg::ST_DONE;
        end
      end
      dac_loader_pkg::ST_HOLD: begin
        if (wait_cnt == '0) begin
          if (!second) begin
            next_state = dac_loader_pkg::ST_SETUP;
            next_wait = cyc(`DATA_SETUP_CYC);
          end else if (req.mode == dac_loader_pkg::MODE_SEPARATE) begin
            next_state = dac_loader_pkg::ST_LOAD;
            next_wait = cyc(`STROBE_LOW_CYC);
          end else begin
            next_state = dac_loader_pkg::ST_DONE;
          end
        end
      end
      dac_loader_pkg::ST_LOAD: begin
        if (wait_cnt == '0) begin
          next_state = dac_loader_pkg::ST_DONE;
        end
      end
      dac_loader_pkg::ST_DONE: next_state = dac_loader_pkg::ST_IDLE;
      default: next_state = dac_loader_pkg::ST_IDLE;
    endcase
  end

  // Pin levels for the next cycle; selects frame the write strobe on both sides
  always_comb begin
    next_pins = '{data: pins.data, low_byte_select_n: 1'b1, high_nibble_select_n: 1'b1,
                  write_n: 1'b1, load_output_n: 1'b1};
    case (next_state)
      dac_loader_pkg::ST_SETUP, dac_loader_pkg::ST_STROBE, dac_loader_pkg::ST_HOLD,
      dac_loader_pkg::ST_OVERLAP: begin
        next_pins.data = section_byte(next_req.code, next_high);
        next_pins.low_byte_select_n = next_high;
        next_pins.high_nibble_select_n = !next_high;
        next_pins.write_n = (next_state != dac_loader_pkg::ST_STROBE);
        next_pins.load_output_n = !(next_tied &&
                                    next_state != dac_loader_pkg::ST_HOLD);
      end
      dac_loader_pkg::ST_LOAD: next_pins.load_output_n = 1'b0;
      default: next_pins.load_output_n = 1'b1;
    endcase
  end

  // Section view for the coming cycle; second flips on leaving the first hold.
  // Leaving idle, the request is not yet captured, so the bus takes it from the input
  // and the first section gets its full data setup time.
  always_comb begin
    next_req = (state == dac_loader_pkg::ST_IDLE) ? req_i : req;
    if (state == dac_loader_pkg::ST_IDLE) begin
      next_second = 1'b0;
    end else if (state == dac_loader_pkg::ST_HOLD && next_state == dac_loader_pkg::ST_SETUP) begin
      next_second = 1'b1;
    end else begin
      next_second = second;
    end
    next_high = high_first(next_req.mode) ^ next_second;
    next_tied = next_second && is_auto(next_req.mode);
  end

  // State and wait counter
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= dac_loader_pkg::ST_IDLE;
      wait_cnt <= '0;
      second <= 1'b0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait;
      second <= next_second;
    end
  end

  // Request capture; the request is held for the whole transfer
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req <= '{code: `CODE_RESET, mode: dac_loader_pkg::MODE_SEPARATE, bipolar: 1'b0};
    end else if (state == dac_loader_pkg::ST_IDLE && req_valid_i) begin
      req <= req_i;
    end
  end

  // Shadow of the device latches: staging after any write, output after a transfer
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      staged <= `CODE_RESET;
      applied_code_o <= `CODE_RESET;
      done_o <= 1'b0;
      req_ready_o <= 1'b0;
    end else begin
      if (state == dac_loader_pkg::ST_STROBE && wait_cnt == '0) begin
        if (cur_high) staged[11:8] <= req.code[11:8];
        else staged[7:0] <= req.code[7:0];
      end
      // Stage-only keeps the old output, as the device latch is untouched.
      // A transfer copies the staging shadow, which by now holds both sections.
      if (next_state == dac_loader_pkg::ST_DONE && req.mode != dac_loader_pkg::MODE_STAGE_ONLY)
        applied_code_o <= staged;
      done_o <= (next_state == dac_loader_pkg::ST_DONE);
      req_ready_o <= (next_state == dac_loader_pkg::ST_IDLE);
    end
  end

  // Pins leave through one register stage, so the converter never sees a glitch
  dac_pin_reg u_pins (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .next_pins_i(next_pins),
    .pins_o(pins)
  );

  // Top-level pins come straight from that register stage
  assign data_o = pins.data;
  assign low_byte_select_n_o = pins.low_byte_select_n;
  assign high_nibble_select_n_o = pins.high_nibble_select_n;
  assign write_n_o = pins.write_n;
  assign load_output_n_o = pins.load_output_n;
endmodule : dac_byte_loader_host

// file: common/dac_loader_consts.svh
// Constants of the host-side loader for the double-buffered 12-bit converter.
// Assumes a 125 MHz system clock; times are given in ns and turned into cycles.
`ifndef DAC_LOADER_CONSTS_SVH
`define DAC_LOADER_CONSTS_SVH
`define CLK_PERIOD_NS 8
`define DATA_SETUP_NS 40
`define STROBE_LOW_NS 80
`define SELECT_HOLD_NS 16
`define OVERLAP_HOLD_TIME_NS 40
`define CYCLES_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_SETUP_CYC `CYCLES_MIN(`DATA_SETUP_NS)
`define STROBE_LOW_CYC `CYCLES_MIN(`STROBE_LOW_NS)
`define SELECT_HOLD_CYC `CYCLES_MIN(`SELECT_HOLD_NS)
`define OVERLAP_HOLD_CYC `CYCLES_MIN(`OVERLAP_HOLD_TIME_NS)
`define LOW_BYTE_LSB 0
`define HIGH_NIBBLE_LSB 8
`define BIPOLAR_ZERO_CODE 12'h800
`define CODE_RESET 12'h000
`define WAIT_W 5
`endif

// file: common/dac_loader_pkg.sv
// Types shared by the host-side loader and its pin driver.
// Assumes the constants header is included where the numbers are needed.
package dac_loader_pkg;
  // Transfer modes chosen per request
  typedef enum logic [1:0] {
    MODE_SEPARATE = 2'h0,  // Two writes, then a standalone load strobe
    MODE_AUTO_HIGH = 2'h1, // Load tied to high-nibble select: low byte first
    MODE_AUTO_LOW = 2'h2,  // Load tied to low-byte select: high nibble first
    MODE_STAGE_ONLY = 2'h3 // Two writes, no transfer
  } mode_t;

  typedef struct packed {
    logic [11:0] code;
    mode_t mode;
    logic bipolar;
  } request_t;

  // Pin levels driven toward the converter
  typedef struct packed {
    logic [7:0] data;
    logic low_byte_select_n;
    logic high_nibble_select_n;
    logic write_n;
    logic load_output_n;
  } pins_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SETUP = 7'h02,
    ST_STROBE = 7'h04,
    ST_HOLD = 7'h08,
    ST_LOAD = 7'h10,
    ST_OVERLAP = 7'h20,
    ST_DONE = 7'h40
  } state_t;
endpackage : dac_loader_pkg

// file: rtl/dac_pin_reg.sv
// Output register stage for the converter pins.
// Assumes the controller presents the next pin levels on the same clock.
`timescale 1ns/10ps
module dac_pin_reg (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire dac_loader_pkg::pins_t next_pins_i,
  output dac_loader_pkg::pins_t pins_o
);
  // All strobes idle high at reset so the converter sees no write or load
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pins_o <= '{data: 8'h00, low_byte_select_n: 1'b1, high_nibble_select_n: 1'b1,
                 write_n: 1'b1, load_output_n: 1'b1};
    end else begin
      pins_o <= next_pins_i;
    end
  end
endmodule : dac_pin_reg

// file: tb/dac_loader_checker_assertions.sv
// Assertions on the loader's pins and handshake.
// Assumes it is bound to the loader's top module; one clock domain.
`timescale 1ns/10ps
module dac_loader_checker (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire dac_loader_pkg::request_t req_i,
  input wire logic req_ready_o,
  input wire logic done_o,
  input wire logic [11:0] applied_code_o,
  input wire logic [7:0] data_o,
  input wire logic low_byte_select_n_o,
  input wire logic high_nibble_select_n_o,
  input wire logic write_n_o,
  input wire logic load_output_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // Write ends while the output latch is still open
  sequence overlap_rise_s;
    $rose(write_n_o) && !load_output_n_o;
  endsequence
  // Load falls alone or together with the tied select
  sequence load_fall_s;
    $fell(load_output_n_o);
  endsequence
  one_section_a: assert property (
    !write_n_o |-> low_byte_select_n_o != high_nibble_select_n_o)
    else $error("write strobe low without exactly one select");
  nibble_lines_a: assert property (
    !write_n_o && !high_nibble_select_n_o |-> data_o[7:4] == 4'h0)
    else $error("upper bus lines not zero in nibble write");
  data_frozen_a: assert property (!write_n_o |-> $stable(data_o))
    else $error("bus changed while write strobe low");
  write_width_a: assert property ($fell(write_n_o) |-> (!write_n_o) [*8])
    else $error("write strobe too short");
  overlap_hold_a: assert property (overlap_rise_s |-> (!load_output_n_o) [*5])
    else $error("load released too soon after write");
  auto_tie_a: assert property (
    load_fall_s |-> (low_byte_select_n_o && high_nibble_select_n_o)
    || $fell(low_byte_select_n_o) || $fell(high_nibble_select_n_o))
    else $error("load fell apart from its tied select");
  idle_quiet_a: assert property (
    req_ready_o |-> write_n_o && load_output_n_o
    && low_byte_select_n_o && high_nibble_select_n_o)
    else $error("strobes active while idle");
  take_busy_a: assert property (req_ready_o && req_valid_i |=> !req_ready_o)
    else $error("ready stayed high after a request was taken");
  done_pulse_a: assert property (done_o |=> !done_o ##[0:1] req_ready_o)
    else $error("done not a single pulse followed by ready");
endmodule : dac_loader_checker
bind dac_byte_loader_host dac_loader_checker chk_u (.clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
  .done_o(done_o), .applied_code_o(applied_code_o), .data_o(data_o),
  .low_byte_select_n_o(low_byte_select_n_o), .high_nibble_select_n_o(high_nibble_select_n_o),
  .write_n_o(write_n_o), .load_output_n_o(load_output_n_o));

// file: tb/dac_latch_model.sv
// Behavioural double-buffered converter latches.
// Assumes pins come straight from the host; no clock, no clear input.
`timescale 1ns/10ps
module dac_latch_model (
  input wire logic [7:0] data_i,
  input wire logic low_byte_select_n_i,
  input wire logic high_nibble_select_n_i,
  input wire logic write_n_i,
  input wire logic load_output_n_i,
  output logic [11:0] staged_o,
  output logic [11:0] code_o
);
  // Power-up zero, since no clear pin exists
  initial staged_o = 12'h000;
  initial code_o = 12'h000;
  // Sections follow the bus while selected with write low, hold otherwise
  always @* begin
    if (!write_n_i && !low_byte_select_n_i) staged_o[7:0] = data_i;
    if (!write_n_i && !high_nibble_select_n_i) staged_o[11:8] = data_i[3:0];
  end
  // Output latch open while load low, untimed to the write
  always @* begin
    if (!load_output_n_i) code_o = staged_o;
  end
endmodule : dac_latch_model

// file: tb/dac_byte_loader_host_tb.sv
// Self-checking bench: host loader driving the latch model.
// Assumes the checker is bound in; codes come from a fixed LFSR.
`timescale 1ns/10ps
module dac_byte_loader_host_tb;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  dac_loader_pkg::request_t req_i = '0;
  logic req_ready_o, done_o, low_byte_select_n_o, high_nibble_select_n_o;
  logic write_n_o, load_output_n_o;
  logic [11:0] applied_code_o, staged, code, exp_out = 12'h000;
  logic [11:0] exp_q[$];
  logic [7:0] data_o;
  logic [15:0] lfsr = 16'h001B;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  dac_byte_loader_host dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .applied_code_o(applied_code_o), .data_o(data_o), .low_byte_select_n_o(low_byte_select_n_o),
    .high_nibble_select_n_o(high_nibble_select_n_o), .write_n_o(write_n_o),
    .load_output_n_o(load_output_n_o));
  dac_latch_model dev_u (.data_i(data_o), .low_byte_select_n_i(low_byte_select_n_o),
    .high_nibble_select_n_i(high_nibble_select_n_o), .write_n_i(write_n_o),
    .load_output_n_i(load_output_n_o), .staged_o(staged), .code_o(code));
  initial forever #4 clk_sys_i = ~clk_sys_i;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic test_done;
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // Ceiling well above 16 transfers of about 36 to 46 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end
  // Valid is held until taken; bounded waits avoid a silent hang
  task automatic send(input dac_loader_pkg::mode_t m, input logic [11:0] c);
    int n;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_i <= '{code: c, mode: m, bipolar: lfsr[0]};
    exp_q.push_back(c);
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys_i);
      if (req_ready_o === 1'b1) break;
    end
    // A wait that runs out is a mismatch, so a stuck handshake cannot pass
    if (n == 50) begin
      fails++;
      $display("unexpected at %0t: request not taken", $time);
    end
    req_valid_i <= 1'b0;
    if (m != dac_loader_pkg::MODE_STAGE_ONLY) exp_out = c;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys_i);
      if (done_o === 1'b1) break;
    end
    if (n == 100) begin
      fails++;
      $display("unexpected at %0t: no done pulse", $time);
    end
    @(negedge clk_sys_i);
    check(staged, exp_q.pop_front());
    check(code, exp_out);
    check(applied_code_o, exp_out);
  endtask : send
  initial begin
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(negedge clk_sys_i);
    check(applied_code_o, 12'h000);
    check(code, 12'h000);
    @(posedge clk_sys_i);
    // Full-scale, zero and midscale codes plus 12'h5A3, every mode once, then random codes and modes
    send(dac_loader_pkg::MODE_SEPARATE, 12'hFFF);
    send(dac_loader_pkg::MODE_AUTO_HIGH, 12'h000);
    send(dac_loader_pkg::MODE_AUTO_LOW, 12'h800);
    send(dac_loader_pkg::MODE_STAGE_ONLY, 12'h5A3);
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      send(dac_loader_pkg::mode_t'(lfsr[13:12]), lfsr[11:0]);
    end
    test_done();
  end
endmodule : dac_byte_loader_host_tb
